// [hw/power_loss_restart_control.v]
// Power-loss restart sequencer with an AXI4-Lite register slave.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "plr_defines.vh"

// Contract
// [R1] Action selector: 0 trip now, 1 trip on recovery, 4 saved restart, 5 start restart.
// [R2] Bus undervoltage while running is taken as the start of a supply loss.
// [R3] Code 0: outputs off at once, alarm raised, no automatic restart.
// [R4] Code 1: outputs off without alarm; alarm only once supply recovers.
// [R5] Code 4: present output frequency is captured on undervoltage.
// [R6] Code 4: restart at captured frequency, limiter matches speed, ramp back up.
// [R7] With code 4 the configuring party also enables the overcurrent limiter.
// [R8] Code 5: outputs off; after recovery a run command restarts at start frequency.
// [R9] Restart waits at least half a second after undervoltage detection.
// [R10] Wait two seconds for run; in window restart, later restart at start frequency.
// [R11] External circuitry reasserts run within two seconds or latches it.
// [R12] Coast-to-stop during loss abandons the wait; next run uses start frequency.
// [R13] Start frequency ranges zero to sixty hertz in tenth-hertz steps.
// [R14] Inputs are sampled synchronous levels; windows counted from the system clock.
module power_loss_restart_control #(
   parameter DEAD_CYCLES = `DEAD_CYCLES,
   parameter WAIT_CYCLES = `WAIT_CYCLES,
   parameter FW          = 10
) (
   // Clock, reset, enable
   input  wire          aclk,
   input  wire          aresetn,
   input  wire          clk_en,
   // AXI4-Lite slave
   input  wire [4:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [4:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Drive side
   input  wire          undervoltage,
   input  wire          run_command,
   input  wire          coast_stop_command,
   input  wire [FW-1:0] output_frequency,
   input  wire          speed_matched,
   output reg           outputs_enable_q,
   output reg           restart_q,
   output reg  [FW-1:0] restart_frequency_q,
   output reg           limiter_search_q,
   output reg           overcurrent_limiter_enable_q,
   output reg           uv_alarm_q,
   output wire          irq
);

   // ----------------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_RUN  = 3'h1;
   localparam [2:0] S_LOST = 3'h2;
   localparam [2:0] S_DEAD = 3'h3;
   localparam [2:0] S_WAIT = 3'h4;
   localparam [2:0] S_TRIP = 3'h5;
   localparam [2:0] S_SYNC = 3'h6;

   // ----------------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------------
   reg [2:0] meta_q;
   reg [2:0] sync_q;
   wire uv_s   = sync_q[0];
   wire run_s  = sync_q[1];
   wire coast_s = sync_q[2];

   // The undervoltage, run and coast levels cross two flip-flops before the sequencer reads any of them.
   // The first stage may be metastable, so nothing else looks at it.

   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 3'h0;
         sync_q <= 3'h0;
      end else if (clk_en) begin
         meta_q <= {coast_stop_command, run_command, undervoltage}; // R14
         sync_q <= meta_q;
      end
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   reg [2:0]    sel_q;
   reg [FW-1:0] startf_q;
   reg [3:0]    irq_stat_q;
   reg [3:0]    irq_mask_q;
   reg [2:0]    state_q;
   reg [FW-1:0] saved_q;
   reg          cold_start_q;
   reg [31:0]   cnt_q;
   reg [4:0]    awaddr_q;
   reg [31:0]   wdata_q;
   reg          aw_full_q;
   reg          w_full_q;
   reg          alarm_clr;
   reg [3:0]    ev;

   // The interrupt stays high while any unmasked status bit is set.
   assign irq = |(irq_stat_q & irq_mask_q);
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Address and data wait in their own slots until both have arrived; the
   // register is updated and the response raised in the same cycle.
   wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   wire wr_ctrl  = do_write && (awaddr_q == `CTRL_OFF);
   wire wr_sf    = do_write && (awaddr_q == `STARTF_OFF);
   wire wr_stat  = do_write && (awaddr_q == `IRQ_STAT_OFF);
   wire wr_mask  = do_write && (awaddr_q == `IRQ_MASK_OFF);
   wire hit      = (awaddr_q == `CTRL_OFF) || (awaddr_q == `STARTF_OFF) || (awaddr_q == `STATUS_OFF) ||
                   (awaddr_q == `IRQ_STAT_OFF) || (awaddr_q == `IRQ_MASK_OFF);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q    <= 1'b0;
         w_full_q     <= 1'b0;
         awaddr_q     <= 5'h00;
         wdata_q      <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         sel_q        <= `CTRL_RESET;
         overcurrent_limiter_enable_q <= 1'b0;
         startf_q     <= `STARTF_RESET;
         irq_mask_q   <= 4'h0;
         alarm_clr    <= 1'b0;
      end else if (clk_en) begin
         alarm_clr <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[4:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
         if (do_write) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= hit ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl) begin
            sel_q <= wdata_q[`CTRL_SEL_LSB+2:`CTRL_SEL_LSB]; // R1
            overcurrent_limiter_enable_q <= wdata_q[`CTRL_OCL_BIT]; // R7
            alarm_clr <= wdata_q[`CTRL_CLR_BIT];
         end
         if (wr_sf) begin
            startf_q <= (wdata_q[FW-1:0] > `STARTF_MAX) ? `STARTF_MAX : wdata_q[FW-1:0]; // R13
         end
         if (wr_mask) begin
            irq_mask_q <= wdata_q[3:0];
         end
      end
   end

   // Set wins over the write-one clear.
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 4'h0;
      end else if (clk_en) begin
         irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[3:0] : 4'h0)) | ev;
      end
   end

   // A read is answered on the edge that takes its address; an unmapped
   // offset returns zero with an error response.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case ({s_axi_araddr[4:2], 2'b00})
               `CTRL_OFF:     s_axi_rdata <= {27'h0, overcurrent_limiter_enable_q, 1'b0, sel_q};
               `STARTF_OFF:   s_axi_rdata <= {{(32-FW){1'b0}}, startf_q};
               `STATUS_OFF:   s_axi_rdata <= {{(16-FW){1'b0}}, saved_q, 8'h0, uv_alarm_q,
                                              outputs_enable_q, cold_start_q, 2'h0, state_q};
               `IRQ_STAT_OFF: s_axi_rdata <= {28'h0, irq_stat_q};
               `IRQ_MASK_OFF: s_axi_rdata <= {28'h0, irq_mask_q};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------------
   // The dead time runs from the cycle in which undervoltage is acted on, so a
   // loss shorter than the dead time still waits the full interval. The wait
   // window for a run command starts only once the dead time is over.
   wire dead_done = (cnt_q >= DEAD_CYCLES - 1);
   wire wait_done = (cnt_q >= WAIT_CYCLES - 1);

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q             <= S_IDLE;
         cnt_q               <= 32'h0;
         saved_q             <= {FW{1'b0}};
         cold_start_q        <= 1'b0;
         outputs_enable_q    <= 1'b0;
         restart_q           <= 1'b0;
         restart_frequency_q <= {FW{1'b0}};
         limiter_search_q    <= 1'b0;
         uv_alarm_q          <= 1'b0;
         ev                  <= 4'h0;
      end else if (clk_en) begin
         restart_q <= 1'b0;
         ev        <= 4'h0;
         // An alarm clear is ignored while undervoltage is still present.
         if (alarm_clr && !uv_s) begin
            uv_alarm_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               outputs_enable_q <= 1'b0;
               if (run_s && !uv_s && !uv_alarm_q) begin
                  outputs_enable_q    <= 1'b1;
                  restart_q           <= 1'b1;
                  restart_frequency_q <= startf_q;
                  state_q             <= S_RUN;
               end
            end
            // While a saved-frequency restart searches, the limiter lowers the frequency;
            // once speed is matched the captured frequency is handed back to the ramp.
            S_RUN: begin
               if (uv_s) begin // R2
                  outputs_enable_q <= 1'b0;
                  limiter_search_q <= 1'b0;
                  ev[`IRQ_UV_BIT]  <= 1'b1;
                  cnt_q            <= 32'h0;
                  cold_start_q     <= 1'b0;
                  saved_q          <= output_frequency; // R5
                  if (sel_q == `ACT_TRIP_NOW) begin
                     uv_alarm_q         <= 1'b1; // R3
                     ev[`IRQ_ALARM_BIT] <= 1'b1;
                     state_q            <= S_TRIP;
                  end else begin
                     state_q <= S_LOST; // R4 R8
                  end
               end else if (!run_s || coast_s) begin
                  outputs_enable_q <= 1'b0;
                  limiter_search_q <= 1'b0;
                  state_q          <= S_IDLE;
               end else if (limiter_search_q && speed_matched) begin
                  limiter_search_q    <= 1'b0; // R6
                  restart_frequency_q <= saved_q;
               end
            end
            // A coast command seen at any time during the loss forces a cold start.
            S_LOST: begin
               if (!dead_done) begin
                  cnt_q <= cnt_q + 32'h1;
               end
               if (coast_s) begin
                  cold_start_q <= 1'b1; // R12
               end
               if (!uv_s) begin
                  if (sel_q == `ACT_TRIP_LATER) begin
                     uv_alarm_q         <= 1'b1; // R4
                     ev[`IRQ_ALARM_BIT] <= 1'b1;
                     state_q            <= S_TRIP;
                  end else if (cold_start_q || coast_s) begin
                     state_q <= S_IDLE; // R12
                  end else begin
                     state_q <= S_DEAD;
                  end
               end
            end
            S_DEAD: begin
               if (uv_s) begin
                  state_q <= S_LOST;
               end else if (dead_done) begin // R9
                  cnt_q   <= 32'h0;
                  state_q <= S_WAIT;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            // Without a run command inside the window the sequencer drops to idle,
            // where a later run command starts from the start frequency.
            S_WAIT: begin
               cnt_q <= cnt_q + 32'h1;
               if (uv_s) begin
                  cnt_q   <= 32'h0;
                  state_q <= S_LOST;
               end else if (coast_s) begin
                  state_q <= S_IDLE; // R12
               end else if (run_s) begin // R10
                  outputs_enable_q    <= 1'b1;
                  restart_q           <= 1'b1;
                  ev[`IRQ_RESTART_BIT] <= 1'b1;
                  state_q             <= S_RUN;
                  if (sel_q == `ACT_RESTART_SAVED) begin
                     restart_frequency_q <= saved_q; // R6
                     limiter_search_q    <= 1'b1;
                  end else begin
                     restart_frequency_q <= startf_q; // R8
                  end
               end else if (wait_done) begin
                  ev[`IRQ_TIMEOUT_BIT] <= 1'b1; // R10
                  state_q              <= S_IDLE;
               end
            end
            // A trip is left only after software has cleared the alarm.
            S_TRIP: begin
               outputs_enable_q <= 1'b0;
               if (!uv_alarm_q) begin
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule // power_loss_restart_control

// [pkg/plr_defines.vh]
// Constants for the power-loss restart sequencer.
`ifndef PLR_DEFINES_VH
`define PLR_DEFINES_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CTRL_OFF            5'h00
`define STARTF_OFF          5'h04
`define STATUS_OFF          5'h08
`define IRQ_STAT_OFF        5'h0c
`define IRQ_MASK_OFF        5'h10
// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define CTRL_SEL_LSB        0
`define CTRL_OCL_BIT        4
`define CTRL_CLR_BIT        8
`define ACT_TRIP_NOW        3'h0
`define ACT_TRIP_LATER      3'h1
`define ACT_RESTART_SAVED   3'h4
`define ACT_RESTART_START   3'h5
`define CTRL_RESET          3'h0
`define STARTF_MAX          10'h258
`define STARTF_RESET        10'h000
`define IRQ_UV_BIT          0
`define IRQ_ALARM_BIT       1
`define IRQ_RESTART_BIT     2
`define IRQ_TIMEOUT_BIT     3
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ              10000000
`define DEAD_MS             500
`define WAIT_MS             2000
`define DEAD_CYCLES         ((`CLK_HZ / 1000) * `DEAD_MS)
`define WAIT_CYCLES         ((`CLK_HZ / 1000) * `WAIT_MS)
`endif

// [dv/plr_monitor.sv]
// Port-level assertions for the power-loss restart sequencer.
`timescale 1ns/1ps
module plr_monitor #(
   parameter DEAD_CYCLES = 20,
   parameter FW          = 10
) (
   // Clock and reset
   input wire          aclk,
   input wire          aresetn,
   // Drive side
   input wire          undervoltage,
   input wire          run_command,
   input wire          speed_matched,
   input wire          outputs_enable_q,
   input wire          restart_q,
   input wire [FW-1:0] restart_frequency_q,
   input wire          limiter_search_q,
   input wire          uv_alarm_q
);
   reg     uv_prev_q;
   integer since_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Cycles since the last undervoltage onset, saturating at the dead time.
   always @(posedge aclk) begin
      uv_prev_q <= undervoltage;
      if (!aresetn)
         since_q <= DEAD_CYCLES;
      else if (undervoltage && !uv_prev_q)
         since_q <= 0;
      else if (since_q < DEAD_CYCLES)
         since_q <= since_q + 1;
   end
   restart_pulse_a: assert property (restart_q |=> !restart_q && outputs_enable_q)
      else $error("restart pulse not followed by running outputs");
   dead_time_a: assert property (restart_q |-> since_q == DEAD_CYCLES)
      else $error("restart issued inside the dead time");
   uv_shutdown_a: assert property (outputs_enable_q && undervoltage |-> ##[1:4] !outputs_enable_q)
      else $error("outputs still on after undervoltage");
   run_cause_a: assert property (restart_q |-> $past(run_command, 2))
      else $error("restart without a run command");
   search_entry_a: assert property ($rose(limiter_search_q) |-> restart_q || $past(restart_q))
      else $error("limiter search began without a restart");
   search_exit_a: assert property (limiter_search_q && speed_matched |-> ##[1:4] !limiter_search_q)
      else $error("limiter search kept after speed match");
   alarm_off_a: assert property (uv_alarm_q |-> !outputs_enable_q)
      else $error("outputs on while alarm stands");
   freq_range_a: assert property (restart_q |-> restart_frequency_q <= 10'h258)
      else $error("restart frequency above range");
endmodule // plr_monitor

bind power_loss_restart_control plr_monitor #(.DEAD_CYCLES(DEAD_CYCLES), .FW(FW)) mon (
   .aclk(aclk), .aresetn(aresetn), .undervoltage(undervoltage), .run_command(run_command),
   .speed_matched(speed_matched), .outputs_enable_q(outputs_enable_q), .restart_q(restart_q),
   .restart_frequency_q(restart_frequency_q), .limiter_search_q(limiter_search_q), .uv_alarm_q(uv_alarm_q));

// [dv/drive_stage_model.sv]
// Output stage and motor model facing the sequencer.
`timescale 1ns/1ps
module drive_stage_model #(
   parameter FW = 10
) (
   // Clock
   input  wire          aclk,
   // Commands from the sequencer, and the set frequency from the bench
   input  wire          outputs_enable_q,
   input  wire          restart_q,
   input  wire [FW-1:0] restart_frequency_q,
   input  wire          limiter_search_q,
   input  wire [FW-1:0] set_frequency,
   // Feedback to the sequencer
   output reg  [FW-1:0] output_frequency = 0,
   output reg           speed_matched = 0
);
   reg [FW-1:0] motor_speed_q = 0;
   // The motor coasts down while the stage is off; the limiter pulls frequency to it.
   always @(posedge aclk) begin
      speed_matched <= limiter_search_q && !restart_q && output_frequency <= motor_speed_q;
      if (restart_q)
         output_frequency <= restart_frequency_q;
      else if (limiter_search_q && output_frequency > motor_speed_q)
         output_frequency <= output_frequency - 1'b1;
      else
         output_frequency <= outputs_enable_q ? set_frequency : {FW{1'b0}};
      if (outputs_enable_q && !limiter_search_q)
         motor_speed_q <= output_frequency;
      else if (!outputs_enable_q && motor_speed_q != 0)
         motor_speed_q <= motor_speed_q - 1'b1;
   end
endmodule // drive_stage_model

// [dv/power_loss_restart_control_bench.sv]
// Self-checking bench for the power-loss restart sequencer.
`timescale 1ns/1ps
`include "plr_defines.vh"
module power_loss_restart_control_bench;
   localparam DEAD_T = 20;
   localparam WAIT_T = 50;
   reg aclk = 0, aresetn = 0, clk_en = 1, undervoltage = 0, run_command = 0, coast_stop_command = 0;
   reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0, rd;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, searched;
   reg [9:0] set_frequency = 0;
   reg [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, speed_matched, irq;
   wire outputs_enable_q, restart_q, limiter_search_q, overcurrent_limiter_enable_q, uv_alarm_q;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [9:0] restart_frequency_q, output_frequency;
   integer num_errors = 0, compares = 0, cyc = 0, seed = 32'h6d0eadd7;
   integer startf, sel, i, k, n, exp_f, exp_irq;
   integer expq[$];
   power_loss_restart_control #(.DEAD_CYCLES(DEAD_T), .WAIT_CYCLES(WAIT_T)) DUT (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .undervoltage(undervoltage), .run_command(run_command), .coast_stop_command(coast_stop_command),
      .output_frequency(output_frequency), .speed_matched(speed_matched),
      .outputs_enable_q(outputs_enable_q), .restart_q(restart_q), .restart_frequency_q(restart_frequency_q),
      .limiter_search_q(limiter_search_q), .overcurrent_limiter_enable_q(overcurrent_limiter_enable_q),
      .uv_alarm_q(uv_alarm_q), .irq(irq));
   drive_stage_model stage (
      .aclk(aclk), .outputs_enable_q(outputs_enable_q), .restart_q(restart_q),
      .restart_frequency_q(restart_frequency_q), .limiter_search_q(limiter_search_q),
      .set_frequency(set_frequency), .output_frequency(output_frequency), .speed_matched(speed_matched));
   always #50 aclk = ~aclk;
   task check(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // One register transfer; each channel is held until its own handshake edge.
   task axi(input wr, input [4:0] a, input [31:0] d);
      reg aw_t, w_t, ar_t, done;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_araddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= wr;
         s_axi_wvalid <= wr;
         s_axi_bready <= wr;
         s_axi_arvalid <= !wr;
         s_axi_rready <= !wr;
         done = 0;
         while (!done) begin
            @(posedge aclk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            ar_t = s_axi_arvalid & s_axi_arready;
            done = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
            rd = s_axi_rdata;
            rsp = wr ? s_axi_bresp : s_axi_rresp;
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (ar_t) s_axi_arvalid <= 1'b0;
         end
         s_axi_bready <= 1'b0;
         s_axi_rready <= 1'b0;
      end
   endtask
   task drain;
      begin
         n = 0;
         while (expq.size() != 0 && n < 500) begin
            @(posedge aclk);
            n = n + 1;
         end
         check(expq.size(), 0);
      end
   endtask
   // Every restart pulse must match the next expected frequency.
   always @(negedge aclk) begin
      if (restart_q === 1'b1) begin
         exp_f = (expq.size() != 0) ? expq.pop_front() : -1;
         check(restart_frequency_q, exp_f);
      end
      if (limiter_search_q === 1'b1)
         searched = 1;
   end
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 10000) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 5; i = i + 1) begin
         axi(0, 5'(i * 4 + ((i > 1) ? 4 : 0)), 0);
         check(rd, 0);
         check(rsp, (i == 4) ? 2 : 0);
      end
      axi(1, 5'h14, 1);
      check(rsp, 2);
      axi(1, `STARTF_OFF, 32'h3ff);
      axi(0, `STARTF_OFF, 0);
      check(rd, `STARTF_MAX);
      startf = {$random(seed)} % 601;
      axi(1, `STARTF_OFF, startf);
      axi(0, `STARTF_OFF, 0);
      check(rd, startf);
      axi(1, `IRQ_MASK_OFF, 32'hf);
      set_frequency <= 10'(1 + {$random(seed)} % 600);
      clk_en <= 1'b0;
      expq.push_back(startf);
      run_command <= 1'b1;
      repeat (8) @(posedge aclk);
      check(outputs_enable_q, 0);
      clk_en <= 1'b1;
      drain;
      axi(1, `IRQ_STAT_OFF, 32'hf);
      for (k = 0; k < 6; k = k + 1) begin
         sel = (k == 1) ? 5 : (k == 4) ? 1 : (k == 5) ? 0 : 4;
         axi(1, `CTRL_OFF, sel + ((sel == 4) ? 16 : 0));
         axi(0, `CTRL_OFF, 0);
         check(rd, sel + ((sel == 4) ? 16 : 0));
         check(overcurrent_limiter_enable_q, sel == 4);
         set_frequency <= 10'(1 + {$random(seed)} % 600);
         searched = 0;
         repeat (4) @(posedge aclk);
         undervoltage <= 1'b1;
         @(posedge aclk);
         if (k == 2 || k == 3)
            run_command <= 1'b0;
         repeat (5) @(posedge aclk);
         check(outputs_enable_q, 0);
         check(uv_alarm_q, sel == 0);
         coast_stop_command <= (k == 3);
         undervoltage <= 1'b0;
         repeat (6) @(posedge aclk);
         coast_stop_command <= 1'b0;
         check(uv_alarm_q, sel < 2);
         repeat ((k == 2) ? DEAD_T + WAIT_T + 10 : (k == 3) ? DEAD_T + 10 : 0) @(posedge aclk);
         if (sel < 2) begin
            repeat (DEAD_T + WAIT_T + 10) @(posedge aclk);
            run_command <= 1'b0;
            axi(1, `CTRL_OFF, sel + 256);
            @(posedge aclk);
            check(uv_alarm_q, 0);
         end
         expq.push_back((k == 0) ? set_frequency : startf);
         run_command <= 1'b1;
         drain;
         repeat (4) @(posedge aclk);
         check(searched, k == 0);
         axi(0, `STATUS_OFF, 0);
         if (k == 0)
            check(rd[25:16], set_frequency);
         exp_irq = 1 + ((k < 2) ? 4 : 0) + ((sel < 2) ? 2 : 0) + ((k == 2) ? 8 : 0);
         if (k == 5)
            axi(1, `IRQ_MASK_OFF, 0);
         check(irq, k != 5);
         axi(0, `IRQ_STAT_OFF, 0);
         check(rd, exp_irq);
         axi(1, `IRQ_STAT_OFF, 32'hf);
         axi(0, `IRQ_STAT_OFF, 0);
         check(rd, 0);
      end
      end_of_test;
   end
endmodule // power_loss_restart_control_bench
